// ==== rtl/brf_cfg.svh ====
// Constants of the bias rail fault and indicator block
// What this block does
// - Mini-buck over-current sets second fault status bit 2.
// - Five-volt rail over-voltage sets second fault status bit 1.
// - Five-volt rail under-voltage sets second fault status bit 0.
// - Under-voltage detection masked by timer from mini-buck soft-start.
// - Gate slew fields: high side bits 4:3, low side bits 2:1.
// - LDO enabled once rail good unless rail enable bit 0 low.
// - LDO target code is six bits, 0.9 V plus 50 mV steps.
// - LDO power-good only raises errors after LDO soft-start completes.
// - LDO under-voltage only drives the LDO fault output; it sets no fault bit and no interrupt.
// - Indicator high only when bias blocks and I2C are ready.
// - Indicator rising edge delayed per indicator control bits 4:3.
// - Indicator control bit 5 high suppresses pulses; resets high.
// - Any fault status bit rising creates an interrupt event.
// - Interrupt drives indicator low for 10 us, then releases.
// - After each pulse wait 480 us for read, else pulse again.
// - Host read of causing register clears both fault registers.
// - Logic state kept through device reset sequence while supply valid.
// - Fault bits still set after reboot resume pulsing at once.
// - Soft thermal shutdown stops main buck only, sets first bit 2.
// - Main buck kept off for hiccup, restarts when temperature low.
// - End of input over-voltage lockout sets first fault bit 0.
// - Hard thermal shutdown sets first fault bit 3.
`ifndef BRF_CFG_SVH
`define BRF_CFG_SVH
`define BRF_CLK_MHZ       100
`define BRF_PULSE_US      10
`define BRF_WAIT_US       480
`define BRF_PULSE_CYC     (`BRF_PULSE_US * `BRF_CLK_MHZ)
`define BRF_WAIT_CYC      (`BRF_WAIT_US * `BRF_CLK_MHZ)
`define BRF_UVMASK_CYC    1000
`define BRF_HICCUP_CYC    100000
`define BRF_DLY0_CYC      0
`define BRF_DLY1_CYC      100
`define BRF_DLY2_CYC      1000
`define BRF_DLY3_CYC      10000
`define BRF_CNT_W         24
`define BRF_F1_OVLO       0
`define BRF_F1_SOFT_TSD   2
`define BRF_F1_HARD_TSD   3
`define BRF_F2_UV         0
`define BRF_F2_OV         1
`define BRF_F2_OC         2
`define BRF_HS_HI         4
`define BRF_HS_LO         3
`define BRF_LS_HI         2
`define BRF_LS_LO         1
`define BRF_DLY_HI        4
`define BRF_DLY_LO        3
`define BRF_IRQ_OFF_BIT   5
`define BRF_LDO_EN_BIT    0
`define BRF_LDO_BASE_MV   900
`define BRF_LDO_STEP_MV   50
`define BRF_SYNC_W        9
`endif

// ==== rtl/brf_pkg.sv ====
// Types of the bias rail fault and indicator block
`include "brf_cfg.svh"
package brf_pkg;
  typedef enum logic [1:0] {
    BRF_IDLE  = 2'b00,
    BRF_PULSE = 2'b01,
    BRF_WAIT  = 2'b10
  } brf_irq_st_t;
  typedef logic [`BRF_CNT_W-1:0] brf_cnt_t;
endpackage

// ==== rtl/brf_sync.sv ====
// Two-flop synchroniser for analog comparator levels
`timescale 1ns/1ps
`include "brf_cfg.svh"
module brf_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Levels
  brf_sync_if.dst  bus
);
  logic [`BRF_SYNC_W-1:0] meta_r;
  logic [`BRF_SYNC_W-1:0] sync_r;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= bus.raw;
      sync_r <= meta_r;
    end
  end
  assign bus.sync = sync_r;
endmodule // brf_sync

// ==== rtl/brf_sync_if.sv ====
// Carrier between the top and its synchroniser
`timescale 1ns/1ps
`include "brf_cfg.svh"
interface brf_sync_if;
  logic [`BRF_SYNC_W-1:0] raw;
  logic [`BRF_SYNC_W-1:0] sync;
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface

// ==== rtl/brf_top.sv ====
// Fault flags, bias control and open-drain indicator with interrupts
`timescale 1ns/1ps
`include "brf_cfg.svh"
module brf_top (
  // Clock and power-on reset (supply invalid only)
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Analog comparators (asynchronous)
  input  wire logic       i_minibuck_oc,
  input  wire logic       i_rail_ov,
  input  wire logic       i_rail_uv,
  input  wire logic       i_rail_good,
  input  wire logic       i_ldo_uv,
  input  wire logic       i_ldo_ss_done,
  input  wire logic       i_tsd_soft,
  input  wire logic       i_tsd_hard,
  input  wire logic       i_ovlo,
  // Same-domain status
  input  wire logic       i_softstart_go,
  input  wire logic       i_bias_ready,
  input  wire logic       i_i2c_ready,
  // Register values from the I2C block
  input  wire logic [7:0] i_minibuck_control,
  input  wire logic [7:0] i_rail_enable_control,
  input  wire logic [7:0] i_indicator_control,
  input  wire logic [5:0] i_ldo_voltage_code,
  input  wire logic       i_read_first,
  input  wire logic       i_read_second,
  // Register state back to the I2C block
  output logic [7:0]      o_fault_status_first,
  output logic [7:0]      o_fault_status_second,
  // Analog controls
  output logic [1:0]      o_hs_slew,
  output logic [1:0]      o_ls_slew,
  output logic            o_ldo_enable,
  output logic [11:0]     o_ldo_target_mv,
  output logic            o_main_buck_off,
  output logic            o_ldo_fault,
  // Open-drain indicator: oe low pulls pin low
  output logic            o_bias_good_irq_pin,
  output logic            o_bias_good_irq_pin_oe
);
  ////////////////////////////////////////////////////////////////////
  brf_sync_if sif ();
  assign sif.raw = {i_ovlo, i_tsd_hard, i_tsd_soft, i_ldo_ss_done,
                    i_ldo_uv, i_rail_good, i_rail_uv, i_rail_ov,
                    i_minibuck_oc};
  brf_sync u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .bus      (sif.dst)
  );
  logic s_oc, s_ov, s_uv, s_good, s_ldo_uv, s_ldo_ss;
  logic s_tsd_soft, s_tsd_hard, s_ovlo;
  assign {s_ovlo, s_tsd_hard, s_tsd_soft, s_ldo_ss, s_ldo_uv, s_good,
          s_uv, s_ov, s_oc} = sif.sync;

  function automatic brf_pkg::brf_cnt_t dly_cycles(input logic [1:0] s);
    case (s)
      2'b00:   dly_cycles = `BRF_CNT_W'(`BRF_DLY0_CYC);
      2'b01:   dly_cycles = `BRF_CNT_W'(`BRF_DLY1_CYC);
      2'b10:   dly_cycles = `BRF_CNT_W'(`BRF_DLY2_CYC);
      default: dly_cycles = `BRF_CNT_W'(`BRF_DLY3_CYC);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Controls
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hs_slew       <= 2'h0;
      o_ls_slew       <= 2'h0;
      o_ldo_enable    <= 1'b0;
      o_ldo_target_mv <= 12'h0000;
    end else begin
      o_hs_slew <= i_minibuck_control[`BRF_HS_HI:`BRF_HS_LO];
      o_ls_slew <= i_minibuck_control[`BRF_LS_HI:`BRF_LS_LO];
      o_ldo_enable <= s_good &&
                      i_rail_enable_control[`BRF_LDO_EN_BIT];
      o_ldo_target_mv <= 12'(`BRF_LDO_BASE_MV) +
          12'(`BRF_LDO_STEP_MV) * {6'h00, i_ldo_voltage_code};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Under-voltage mask timer from soft-start
  brf_pkg::brf_cnt_t uvm_cnt_r;
  logic              uv_armed;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      uvm_cnt_r <= '0;
    end else if (i_softstart_go) begin
      uvm_cnt_r <= `BRF_CNT_W'(`BRF_UVMASK_CYC);
    end else if (uvm_cnt_r != '0) begin
      uvm_cnt_r <= uvm_cnt_r - 1'b1;
    end
  end
  assign uv_armed = (uvm_cnt_r == '0) && !i_softstart_go;

  // LDO errors only once active and soft-started
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ldo_fault <= 1'b0;
    end else begin
      o_ldo_fault <= o_ldo_enable && s_ldo_ss && s_ldo_uv;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Fault flags; reset only on supply loss so they survive reboot
  logic ovlo_d_r;
  logic clr_all;
  logic [7:0] set1, set2;
  always_comb begin
    set1 = 8'h00;
    set2 = 8'h00;
    set1[`BRF_F1_OVLO]     = ovlo_d_r && !s_ovlo;
    set1[`BRF_F1_SOFT_TSD] = s_tsd_soft;
    set1[`BRF_F1_HARD_TSD] = s_tsd_hard;
    set2[`BRF_F2_OC]       = s_oc;
    set2[`BRF_F2_OV]       = s_ov;
    set2[`BRF_F2_UV]       = s_uv && uv_armed;
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ovlo_d_r              <= 1'b0;
      o_fault_status_first  <= 8'h00;
      o_fault_status_second <= 8'h00;
    end else begin
      ovlo_d_r <= s_ovlo;
      // Set wins over a read-clear in the same cycle
      o_fault_status_first  <= (clr_all ? 8'h00 : o_fault_status_first)
                               | set1;
      o_fault_status_second <= (clr_all ? 8'h00 : o_fault_status_second)
                               | set2;
    end
  end
  logic [7:0] rise1, rise2;
  assign rise1 = set1 & ~o_fault_status_first;
  assign rise2 = set2 & ~o_fault_status_second;

  ////////////////////////////////////////////////////////////////////
  // Soft thermal shutdown hiccup
  brf_pkg::brf_cnt_t hic_cnt_r;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hic_cnt_r       <= '0;
      o_main_buck_off <= 1'b0;
    end else if (s_tsd_soft) begin
      hic_cnt_r       <= `BRF_CNT_W'(`BRF_HICCUP_CYC);
      o_main_buck_off <= 1'b1;
    end else if (hic_cnt_r != '0) begin
      hic_cnt_r <= hic_cnt_r - 1'b1;
    end else begin
      o_main_buck_off <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Readiness with programmable rising delay
  logic              ready;
  logic              ready_dly_r;
  brf_pkg::brf_cnt_t rdy_cnt_r;
  logic [1:0]        dly_sel;
  assign ready = i_bias_ready && i_i2c_ready && s_good;
  assign dly_sel = i_indicator_control[`BRF_DLY_HI:`BRF_DLY_LO];
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdy_cnt_r   <= '0;
      ready_dly_r <= 1'b0;
    end else if (!ready) begin
      rdy_cnt_r   <= '0;
      ready_dly_r <= 1'b0;
    end else if (rdy_cnt_r >= dly_cycles(dly_sel)) begin
      ready_dly_r <= 1'b1;
    end else begin
      rdy_cnt_r <= rdy_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt pulse sequencer
  brf_pkg::brf_irq_st_t st_r;
  brf_pkg::brf_cnt_t    irq_cnt_r;
  logic                 irq_on;
  logic                 cause_first_r;
  logic                 pending;
  logic                 cause_read;
  assign irq_on  = !i_indicator_control[`BRF_IRQ_OFF_BIT];
  // Leftover flags restart pulsing after reboot
  assign pending = (|rise1) || (|rise2) ||
                   (|o_fault_status_first) || (|o_fault_status_second);
  assign cause_read = cause_first_r ? i_read_first : i_read_second;
  assign clr_all    = (st_r != brf_pkg::BRF_IDLE) && cause_read;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r          <= brf_pkg::BRF_IDLE;
      irq_cnt_r     <= '0;
      cause_first_r <= 1'b0;
    end else begin
      case (st_r)
        brf_pkg::BRF_IDLE: begin
          if (irq_on && ready_dly_r && pending) begin
            st_r          <= brf_pkg::BRF_PULSE;
            irq_cnt_r     <= `BRF_CNT_W'(`BRF_PULSE_CYC - 1);
            cause_first_r <= (|rise1) || (|o_fault_status_first);
          end
        end
        brf_pkg::BRF_PULSE: begin
          if (cause_read || !irq_on) begin
            st_r <= brf_pkg::BRF_IDLE;
          end else if (irq_cnt_r == '0) begin
            st_r      <= brf_pkg::BRF_WAIT;
            irq_cnt_r <= `BRF_CNT_W'(`BRF_WAIT_CYC - 1);
          end else begin
            irq_cnt_r <= irq_cnt_r - 1'b1;
          end
        end
        brf_pkg::BRF_WAIT: begin
          if (cause_read || !irq_on) begin
            st_r <= brf_pkg::BRF_IDLE;
          end else if (irq_cnt_r == '0) begin
            st_r      <= brf_pkg::BRF_PULSE;
            irq_cnt_r <= `BRF_CNT_W'(`BRF_PULSE_CYC - 1);
          end else begin
            irq_cnt_r <= irq_cnt_r - 1'b1;
          end
        end
        default: st_r <= brf_pkg::BRF_IDLE;
      endcase
    end
  end

  // Pin: released high only when ready and not pulsing
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_bias_good_irq_pin    <= 1'b0;
      o_bias_good_irq_pin_oe <= 1'b0;
    end else begin
      o_bias_good_irq_pin <= 1'b0;
      o_bias_good_irq_pin_oe <= ready_dly_r &&
          (st_r != brf_pkg::BRF_PULSE);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pulse length counted apart from the sequencer's own counter
  brf_pkg::brf_cnt_t pulse_len_r;
  logic [15:0]       flags_all;
  assign flags_all = {o_fault_status_first, o_fault_status_second};
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pulse_len_r <= '0;
    end else if (st_r == brf_pkg::BRF_PULSE) begin
      pulse_len_r <= pulse_len_r + 1'b1;
    end else begin
      pulse_len_r <= '0;
    end
  end
  sequence s_pulse_end;
    (st_r == brf_pkg::BRF_PULSE) && (irq_cnt_r == '0) &&
    !cause_read && irq_on;
  endsequence
  sequence s_wait_start;
    st_r == brf_pkg::BRF_WAIT;
  endsequence

  a_pulse_len: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_pulse_end |->
    (pulse_len_r == `BRF_CNT_W'(`BRF_PULSE_CYC - 1)) ##1 s_wait_start)
    else $error("pulse length wrong");
  a_pin_low_pulse: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (st_r == brf_pkg::BRF_PULSE) |=> !o_bias_good_irq_pin_oe)
    else $error("pin not low in pulse");
  a_irq_suppress: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (st_r == brf_pkg::BRF_IDLE) && !irq_on |=> st_r == brf_pkg::BRF_IDLE)
    else $error("pulse while suppressed");
  a_read_clears: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    clr_all && set1 == 8'h00 && set2 == 8'h00 |=> flags_all == 16'h0000)
    else $error("read did not clear");
  a_flags_sticky: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !clr_all |=> (flags_all & $past(flags_all)) == $past(flags_all))
    else $error("flag lost without read");
  a_oc_flag: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_oc |=> o_fault_status_second[`BRF_F2_OC])
    else $error("oc flag missing");
  a_ov_flag: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ov |=> o_fault_status_second[`BRF_F2_OV])
    else $error("ov flag missing");
  a_uv_mask: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_softstart_go && !o_fault_status_second[`BRF_F2_UV] && !clr_all |=>
    !o_fault_status_second[`BRF_F2_UV])
    else $error("uv not masked");
  a_tsd_off: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_tsd_soft |=> o_main_buck_off && o_fault_status_first[`BRF_F1_SOFT_TSD])
    else $error("soft tsd not acted");
  a_ldo_en: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !i_rail_enable_control[`BRF_LDO_EN_BIT] |=> !o_ldo_enable)
    else $error("ldo enabled while off");
  a_ldo_gate: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !s_ldo_ss || !o_ldo_enable |=> !o_ldo_fault)
    else $error("ldo fault before soft-start");
  a_not_ready: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !ready |-> ##2 !o_bias_good_irq_pin_oe)
    else $error("pin released not ready");
endmodule // brf_top

// ==== sim/brf_host.sv ====
// Host microcontroller model on the indicator pin and status reads
`timescale 1ns/1ps
module brf_host (
  // Clock and wired pin level
  input  wire logic       i_clk,
  input  wire logic       i_pin,
  // Status seen over I2C, and low edge on which to read
  input  wire logic [7:0] i_first,
  input  wire logic [3:0] i_need,
  // Read strobes
  output logic            o_read_first,
  output logic            o_read_second
);
  logic [3:0] lows = 4'h0;
  logic       pin_d = 1'b1;
  logic       rf_r = 1'b0;
  logic       rs_r = 1'b0;
  assign o_read_first = rf_r;
  assign o_read_second = rs_r;
  // Reads late so that a pulse or two can go unanswered
  always @(negedge i_clk) begin
    if (i_need == 4'h0) lows = 4'h0;
    if (pin_d && !i_pin) begin
      lows = lows + 4'h1;
      if (lows == i_need) begin
        repeat (20) @(negedge i_clk);
        if (i_first != 8'h00) rf_r = 1'b1;
        else rs_r = 1'b1;
        @(negedge i_clk);
        rf_r = 1'b0;
        rs_r = 1'b0;
        lows = 4'h0;
      end
    end
    pin_d = i_pin;
  end
endmodule // brf_host

// ==== sim/tb.sv ====
// Self-checking bench for the bias fault flags and indicator pin
`timescale 1ns/1ps
module tb;
  logic i_clk, i_resetn, i_rail_uv, i_rail_good, i_ldo_uv, i_ldo_ss_done;
  logic i_softstart_go, i_bias_ready, i_i2c_ready, t_rf, h_rf, h_rs;
  wire  i_minibuck_oc, i_rail_ov, i_tsd_soft, i_tsd_hard, i_ovlo;
  wire  i_read_first, i_read_second, pin;
  logic [7:0] i_minibuck_control, i_rail_enable_control, i_indicator_control;
  logic [5:0] i_ldo_voltage_code;
  logic [7:0] o_fault_status_first, o_fault_status_second;
  logic [1:0] o_hs_slew, o_ls_slew;
  logic [11:0] o_ldo_target_mv;
  logic o_ldo_enable, o_main_buck_off, o_ldo_fault, o_pin, o_oe;
  logic [4:0] cmp;
  logic [3:0] need;
  logic [7:0] ef [5] = '{8'h00, 8'h00, 8'h04, 8'h0c, 8'h0d};
  logic [7:0] es [5] = '{8'h04, 8'h06, 8'h06, 8'h06, 8'h06};
  int fails = 0;
  int num_checks = 0;
  int n;
  wire [15:0] flags = {o_fault_status_first, o_fault_status_second};
  assign {i_ovlo, i_tsd_hard, i_tsd_soft, i_rail_ov, i_minibuck_oc} = cmp;
  assign i_read_first = h_rf | t_rf;
  assign i_read_second = h_rs;
  // Pull-up wins whenever the pin is released
  assign pin = o_oe ? 1'b1 : o_pin;
  brf_top u_dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_minibuck_oc(i_minibuck_oc), .i_rail_ov(i_rail_ov),
    .i_rail_uv(i_rail_uv), .i_rail_good(i_rail_good), .i_ldo_uv(i_ldo_uv),
    .i_ldo_ss_done(i_ldo_ss_done), .i_tsd_soft(i_tsd_soft),
    .i_tsd_hard(i_tsd_hard), .i_ovlo(i_ovlo),
    .i_softstart_go(i_softstart_go), .i_bias_ready(i_bias_ready),
    .i_i2c_ready(i_i2c_ready), .i_minibuck_control(i_minibuck_control),
    .i_rail_enable_control(i_rail_enable_control),
    .i_indicator_control(i_indicator_control),
    .i_ldo_voltage_code(i_ldo_voltage_code), .i_read_first(i_read_first),
    .i_read_second(i_read_second),
    .o_fault_status_first(o_fault_status_first),
    .o_fault_status_second(o_fault_status_second), .o_hs_slew(o_hs_slew),
    .o_ls_slew(o_ls_slew), .o_ldo_enable(o_ldo_enable),
    .o_ldo_target_mv(o_ldo_target_mv), .o_main_buck_off(o_main_buck_off),
    .o_ldo_fault(o_ldo_fault), .o_bias_good_irq_pin(o_pin),
    .o_bias_good_irq_pin_oe(o_oe));
  brf_host u_host (.i_clk(i_clk), .i_pin(pin),
    .i_first(o_fault_status_first), .i_need(need),
    .o_read_first(h_rf), .o_read_second(h_rs));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [15:0] ldo_mv(input logic [5:0] c);
    return 16'(900 + 50 * int'(c));
  endfunction
  // Rising delay of the indicator per select code
  function automatic int dly(input int s);
    return (s == 3) ? 10000 : (s == 2) ? 1000 : (s == 1) ? 100 : 0;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("mismatch at %0t got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  // Counts falling edges until the enable reaches v, bounded by lim
  task automatic wait_oe(input logic v, input int lim, output int k);
    k = 0;
    while (o_oe !== v && k < lim) begin
      @(negedge i_clk);
      k++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #900_000;
    fails++;
    final_report();
  end
  initial begin
    {i_resetn, i_rail_uv, i_rail_good, i_ldo_uv, i_ldo_ss_done} = 5'h00;
    {i_softstart_go, i_bias_ready, i_i2c_ready, t_rf, cmp} = 9'h000;
    {i_minibuck_control, i_ldo_voltage_code, need} = 18'h0_0000;
    i_rail_enable_control = 8'h01;
    i_indicator_control = 8'h20;
    n = $urandom(32'hcf9fc700);
    repeat (3) @(negedge i_clk);
    chk(16'(o_oe), 16'h0000);
    i_resetn = 1'b1;
    {i_bias_ready, i_i2c_ready, i_rail_good} = 3'h7;
    wait_oe(1'b1, 10, n);
    chk(16'(o_oe), 16'h0001);
    for (int s = 1; s < 4; s++) begin
      i_i2c_ready = 1'b0;
      wait_oe(1'b0, 10, n);
      chk(16'(o_oe), 16'h0000);
      chk(16'(o_pin), 16'h0000);
      i_i2c_ready = 1'b1;
      i_indicator_control = {3'h1, 2'(s), 3'h0};
      wait_oe(1'b1, 10100, n);
      chk_rng(n, dly(s), dly(s) + 6);
    end
    i_indicator_control = 8'h20;
    for (int k = 0; k < 8; k++) begin
      @(negedge i_clk);
      i_minibuck_control = 8'($urandom);
      i_rail_enable_control = 8'($urandom);
      i_ldo_voltage_code = (k == 0) ? 6'h3f : 6'($urandom);
      repeat (5) @(negedge i_clk);
      chk(16'(o_hs_slew), 16'(i_minibuck_control[4:3]));
      chk(16'(o_ls_slew), 16'(i_minibuck_control[2:1]));
      chk(16'(o_ldo_enable), 16'(i_rail_enable_control[0]));
      chk(16'(o_ldo_target_mv), ldo_mv(i_ldo_voltage_code));
    end
    i_rail_enable_control = 8'h01;
    i_rail_good = 1'b0;
    repeat (5) @(negedge i_clk);
    chk(16'(o_ldo_enable), 16'h0000);
    i_rail_good = 1'b1;
    // Overlo flag only lands once the lockout ends, hence pulse then drop
    for (int k = 0; k < 5; k++) begin
      cmp = 5'(1 << k);
      repeat (6) @(negedge i_clk);
      cmp = 5'h00;
      repeat (6) @(negedge i_clk);
      chk(flags, {ef[k], es[k]});
    end
    chk(16'(o_main_buck_off), 16'h0001);
    chk(16'(o_oe), 16'h0001);
    t_rf = 1'b1;
    @(negedge i_clk);
    t_rf = 1'b0;
    repeat (3) @(negedge i_clk);
    chk(16'(o_fault_status_first), 16'h000d);
    i_softstart_go = 1'b1;
    @(negedge i_clk);
    i_softstart_go = 1'b0;
    repeat (100) @(negedge i_clk);
    i_rail_uv = 1'b1;
    repeat (10) @(negedge i_clk);
    i_rail_uv = 1'b0;
    repeat (5) @(negedge i_clk);
    chk(16'(o_fault_status_second[0]), 16'h0000);
    repeat (1000) @(negedge i_clk);
    i_rail_uv = 1'b1;
    repeat (10) @(negedge i_clk);
    i_rail_uv = 1'b0;
    chk(16'(o_fault_status_second[0]), 16'h0001);
    i_ldo_uv = 1'b1;
    repeat (6) @(negedge i_clk);
    chk(16'(o_ldo_fault), 16'h0000);
    i_ldo_ss_done = 1'b1;
    repeat (6) @(negedge i_clk);
    chk(16'(o_ldo_fault), 16'h0001);
    i_ldo_uv = 1'b0;
    need = 4'h2;
    // Leftover flags start pulsing as soon as interrupts are allowed
    i_indicator_control = 8'h00;
    wait_oe(1'b0, 20, n);
    chk_rng(n, 1, 8);
    wait_oe(1'b1, 1100, n);
    chk_rng(n, 998, 1002);
    wait_oe(1'b0, 48100, n);
    chk_rng(n, 47998, 48002);
    wait_oe(1'b1, 1100, n);
    chk_rng(n, 18, 30);
    repeat (3) @(negedge i_clk);
    chk({o_fault_status_first, o_fault_status_second}, 16'h0000);
    wait_oe(1'b0, 2000, n);
    chk_rng(n, 2000, 2000);
    need = 4'h1;
    cmp = 5'h01;
    wait_oe(1'b0, 20, n);
    cmp = 5'h00;
    chk_rng(n, 3, 10);
    wait_oe(1'b1, 1100, n);
    chk_rng(n, 18, 30);
    repeat (3) @(negedge i_clk);
    chk({o_fault_status_first, o_fault_status_second}, 16'h0000);
    final_report();
  end
endmodule // tb
